// *** pwr_phy.sv ***
// phy end: power control register, extended alias decode, bvalid edge rxcmds, shared pin
// assumes link keeps reserved bits zero and stays below extended 40h
`timescale 1ns/100ps
// How it works
// R1: register at 3Dh write, 3Eh set, 3Fh clear
// R2: link never writes reserved bits one
// R3: falling bvalid with enable sends alt rxcmd
// R4: rising bvalid with enable sends alt rxcmd
// R5: otg link uses session valid, not edges
// R6: bit 0 picks reset input or switch output
// R7: link sets bit 0 when ganged switch
// R8: extended 00h-3Fh alias immediate registers
// R9: link avoids extended 40h to FFh
// R10: 2Fh holds no data, only gateway
// R11: set ors bits, clear removes ones
// R12: switch mode ignores pin as reset
module pwr_phy (
  input  wire logic clk,            // clock
  input  wire logic sys_rst,        // power-on reset, sync high
  pwr_link_if.phy   lnk,            // link channel
  input  wire logic bvalid_in,      // b-session-valid comparator, async
  input  wire logic shared_pin_i,   // shared_reset_switch_pin level in
  input  wire logic switch_req,     // power switch wanted on
  output logic      shared_pin_o,   // shared pin drive (power_switch_out_low)
  output logic      shared_pin_oe,  // shared pin enable
  output logic      pin_reset_r     // reset from shared pin, held
);
  logic [7:0] power_control_r;
  logic [7:0] power_control_nxt;
  logic       ack_r;
  logic [7:0] rdata_r;
  logic       alt_r;
  logic       pin_o_r;
  logic       pin_oe_r;
  logic       bv_rise;
  logic       bv_fall;
  logic       pin_level;

  // extended space aliases immediate; upper extended range decodes nothing
  wire       in_range   = ~lnk.ext | (lnk.addr < pwr_ctl_pkg::EXT_LIMIT);  // R8
  wire [5:0] eff_addr   = lnk.addr[5:0];
  wire       hit_pc     = in_range & (eff_addr >= pwr_ctl_pkg::ADDR_PWR_WRITE); // R1
  wire       is_wr      = lnk.req & (lnk.op == pwr_ctl_pkg::OP_WRITE);
  wire       is_rd      = lnk.req & (lnk.op == pwr_ctl_pkg::OP_READ);
  // gateway address and holes read zero and take no write
  wire       gateway    = eff_addr == pwr_ctl_pkg::ADDR_EXT_GATEWAY;      // R10
  wire [7:0] wmasked    = lnk.wdata & pwr_ctl_pkg::PWR_CTL_WMASK;          // R2
  wire       do_write   = is_wr & hit_pc & ~gateway & (eff_addr == pwr_ctl_pkg::ADDR_PWR_WRITE);
  wire       do_set     = is_wr & hit_pc & (eff_addr == pwr_ctl_pkg::ADDR_PWR_SET);
  wire       do_clear   = is_wr & hit_pc & (eff_addr == pwr_ctl_pkg::ADDR_PWR_CLEAR);
  wire       switch_mode = power_control_r[pwr_ctl_pkg::BIT_PIN_SELECT];   // R6
  wire       alt_event  = (bv_fall & power_control_r[pwr_ctl_pkg::BIT_FALL_EN]) // R3
                        | (bv_rise & power_control_r[pwr_ctl_pkg::BIT_RISE_EN]); // R4

  always_comb begin
    power_control_nxt = power_control_r;
    if (do_write)
      power_control_nxt = wmasked;                                         // R1
    else if (do_set)
      power_control_nxt = power_control_r | wmasked;                       // R11
    else if (do_clear)
      power_control_nxt = power_control_r & ~lnk.wdata;                    // R11
  end

  edge_sync u_bvalid (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .async_in (bvalid_in),
    .level    (),
    .rise     (bv_rise),
    .fall     (bv_fall)
  );

  edge_sync u_pin (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .async_in (~shared_pin_i),
    .level    (pin_level),
    .rise     (),
    .fall     ()
  );

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      power_control_r <= pwr_ctl_pkg::PWR_CTL_RESET;
      ack_r           <= 1'b0;
      rdata_r         <= 8'h00;
      alt_r           <= 1'b0;
      pin_o_r         <= 1'b1;
      pin_oe_r        <= 1'b0;
      pin_reset_r     <= 1'b0;
    end else begin
      power_control_r <= power_control_nxt;
      ack_r           <= lnk.req;
      rdata_r         <= (is_rd & hit_pc) ? power_control_r : 8'h00;      // R1
      alt_r           <= alt_event;
      pin_oe_r        <= switch_mode;                                      // R6
      pin_o_r         <= ~(switch_mode & switch_req);
      // pin low counts as reset only in input mode; por still resets all
      pin_reset_r     <= ~switch_mode & pin_level;                         // R12
    end
  end

  assign lnk.ack       = ack_r;
  assign lnk.rdata     = rdata_r;
  assign lnk.alt_int   = alt_r;
  assign lnk.pin_sel   = power_control_r[pwr_ctl_pkg::BIT_PIN_SELECT];
  assign shared_pin_o  = pin_o_r;
  assign shared_pin_oe = pin_oe_r;
endmodule // pwr_phy

// *** pwr_ctl_pkg.sv ***
// shared constants for the power control register bank and its ulpi-side register access
// assumes a single 20 MHz clock shared by both ends
package pwr_ctl_pkg;
  localparam logic [5:0] ADDR_PWR_WRITE   = 6'h3D;
  localparam logic [5:0] ADDR_PWR_SET     = 6'h3E;
  localparam logic [5:0] ADDR_PWR_CLEAR   = 6'h3F;
  localparam logic [5:0] ADDR_EXT_GATEWAY = 6'h2F;
  localparam logic [7:0] EXT_LIMIT        = 8'h40;
  localparam int         BIT_FALL_EN      = 3;
  localparam int         BIT_RISE_EN      = 2;
  localparam int         BIT_PIN_SELECT   = 0;
  localparam logic [7:0] PWR_CTL_RESET    = 8'h00;
  localparam logic [7:0] PWR_CTL_WMASK    = 8'h0D;
  // access kinds on the register channel
  localparam logic [1:0] OP_WRITE         = 2'h0;
  localparam logic [1:0] OP_READ          = 2'h1;
  // controller-side register map
  localparam logic [3:0] REG_CMD_ADDR     = 4'h0;
  localparam logic [3:0] REG_CMD_DATA     = 4'h1;
  localparam logic [3:0] REG_CMD_GO       = 4'h2;
  localparam logic [3:0] REG_RD_DATA      = 4'h3;
  localparam logic [3:0] REG_IRQ_STATUS   = 4'h4;
  localparam logic [3:0] REG_IRQ_MASK     = 4'h5;
  localparam logic [3:0] REG_LINK_STATE   = 4'h6;
  localparam int         IRQ_DONE         = 0;
  localparam int         IRQ_ALT          = 1;
  localparam int         IRQ_BAD_ADDR     = 2;
endpackage

// *** pwr_link_if.sv ***
// register channel and event lines between phy register bank and link controller
// assumes both ends on one clock
`timescale 1ns/100ps
interface pwr_link_if;
  logic       req;      // one-cycle access request from link
  logic [1:0] op;       // write or read
  logic       ext;      // address is an extended address
  logic [7:0] addr;     // immediate (low 6 bits) or extended address
  logic [7:0] wdata;    // write data
  logic       ack;      // one-cycle completion from phy
  logic [7:0] rdata;    // read data, valid with ack
  logic       alt_int;  // one-cycle rxcmd with alt interrupt bit
  logic       pin_sel;  // shared pin function as seen by link
  modport phy  (input req, op, ext, addr, wdata, output ack, rdata, alt_int, pin_sel);
  modport link (output req, op, ext, addr, wdata, input ack, rdata, alt_int, pin_sel);
endinterface

// *** edge_sync.sv ***
// two-flop synchroniser with rise and fall pulses
// assumes input is asynchronous to clk
`timescale 1ns/100ps
module edge_sync (
  input  wire logic clk,       // clock
  input  wire logic sys_rst,   // sync reset
  input  wire logic async_in,  // raw input
  output logic      level,     // synchronised level
  output logic      rise,      // low to high pulse
  output logic      fall       // high to low pulse
);
  logic meta_r;
  logic sync_r;
  logic prev_r;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end
  assign level = sync_r;
  assign rise  = sync_r & ~prev_r;
  assign fall  = ~sync_r & prev_r;
endmodule // edge_sync

// *** pwr_link.sv ***
// link end: software register port, drives one phy register access at a time
// assumes phy answers every request one cycle later
`timescale 1ns/100ps
module pwr_link (
  input  wire logic       clk,      // clock
  input  wire logic       sys_rst,  // sync reset high
  pwr_link_if.link        lnk,      // phy channel
  input  wire logic [3:0] sw_addr,  // software address
  input  wire logic [7:0] sw_wdata, // software write data
  input  wire logic       sw_wr,    // write strobe
  input  wire logic       sw_rd,    // read strobe
  output logic      [7:0] sw_rdata, // read data, cycle after strobe
  output logic            irq       // level interrupt
);
  typedef enum logic [1:0] {IDLE = 2'b01, WAIT = 2'b10} st_type;
  st_type     st_r;
  logic [8:0] cmd_addr_r;
  logic [7:0] cmd_data_r;
  logic       req_r;
  logic [1:0] op_r;
  logic [7:0] rd_r;
  logic [2:0] stat_r;
  logic [2:0] mask_r;
  logic [7:0] sw_rdata_r;
  logic       irq_r;

  wire go      = sw_wr & (sw_addr == pwr_ctl_pkg::REG_CMD_GO) & (st_r == IDLE);
  // extended 40h and above refused here to protect the phy
  wire bad     = cmd_addr_r[8] & (cmd_addr_r[7:0] >= pwr_ctl_pkg::EXT_LIMIT); // R9
  // reserved bits stripped before sending to the phy
  wire [7:0] wd = cmd_data_r & pwr_ctl_pkg::PWR_CTL_WMASK;                  // R2
  wire [2:0] ev = {go & bad, lnk.alt_int, lnk.ack};                         // R5
  wire clr_wr  = sw_wr & (sw_addr == pwr_ctl_pkg::REG_IRQ_STATUS);
  wire [2:0] stat_nxt = (stat_r & ~(clr_wr ? sw_wdata[2:0] : 3'h0)) | ev;
  // irq follows the new mask in the same cycle as the new status
  wire       mask_wr  = sw_wr & (sw_addr == pwr_ctl_pkg::REG_IRQ_MASK);
  wire [2:0] mask_nxt = mask_wr ? sw_wdata[2:0] : mask_r;
  wire [7:0] rmux =
    (sw_addr == pwr_ctl_pkg::REG_CMD_ADDR)   ? {cmd_addr_r[8], cmd_addr_r[6:0]} :
    (sw_addr == pwr_ctl_pkg::REG_CMD_DATA)   ? cmd_data_r :
    (sw_addr == pwr_ctl_pkg::REG_RD_DATA)    ? rd_r :
    (sw_addr == pwr_ctl_pkg::REG_IRQ_STATUS) ? {5'h00, stat_r} :
    (sw_addr == pwr_ctl_pkg::REG_IRQ_MASK)   ? {5'h00, mask_r} :
    (sw_addr == pwr_ctl_pkg::REG_LINK_STATE) ? {6'h00, (st_r == WAIT), lnk.pin_sel} :
    8'h00;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r <= IDLE;
      cmd_addr_r <= 9'h000;
      cmd_data_r <= 8'h00;
      req_r <= 1'b0;
      op_r <= 2'h0;
      rd_r <= 8'h00;
      stat_r <= 3'h0;
      mask_r <= 3'h0;
      sw_rdata_r <= 8'h00;
      irq_r <= 1'b0;
    end else begin
      req_r <= go & ~bad;
      stat_r <= stat_nxt;
      irq_r <= |(stat_nxt & mask_nxt);
      mask_r <= mask_nxt;
      sw_rdata_r <= sw_rd ? rmux : 8'h00;
      if (sw_wr & (sw_addr == pwr_ctl_pkg::REG_CMD_ADDR)) cmd_addr_r <= {sw_wdata[7], 1'b0, sw_wdata[6:0]};
      if (sw_wr & (sw_addr == pwr_ctl_pkg::REG_CMD_DATA)) cmd_data_r <= sw_wdata;
      if (go) op_r <= sw_wdata[1:0];
      if (lnk.ack) rd_r <= lnk.rdata;
      case (st_r)
        IDLE: if (go & ~bad) st_r <= WAIT;
        WAIT: if (lnk.ack) st_r <= IDLE;
        default: st_r <= IDLE;
      endcase
    end
  end

  assign lnk.req   = req_r;
  assign lnk.op    = op_r;
  assign lnk.ext   = cmd_addr_r[8];
  assign lnk.addr  = cmd_addr_r[7:0];
  assign lnk.wdata = wd;
  assign sw_rdata  = sw_rdata_r;
  assign irq       = irq_r;
endmodule // pwr_link

// *** pwr_ctl_sva.sv ***
// assertions on the phy/link register channel
// assumes one clock and a sync high reset
`timescale 1ns/100ps
module pwr_ctl_sva (
  input wire logic       clk,     // clock
  input wire logic       sys_rst, // reset
  input wire logic       req,     // request
  input wire logic [1:0] op,      // kind
  input wire logic       ext,     // extended
  input wire logic [7:0] addr,    // address
  input wire logic [7:0] wdata,   // write data
  input wire logic       ack,     // answer
  input wire logic [7:0] rdata,   // read data
  input wire logic       alt_int, // alt rxcmd
  input wire logic       pin_sel  // pin select
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ext alias below 40h means the low six bits name the register
  wire wr_hit = req && op == pwr_ctl_pkg::OP_WRITE && addr[7:6] == 2'h0;
  wire rd_hit = req && op == pwr_ctl_pkg::OP_READ && addr[7:6] == 2'h0;
  a_ack_follows: assert property (req |=> ack) else $error("ack missing");
  a_ack_cause: assert property (ack |-> $past(req)) else $error("stray ack");
  a_write_pin: assert property (wr_hit && addr[5:0] == 6'h3D
    |-> ##2 pin_sel == $past(wdata[0], 2)) else $error("write lost");
  a_set_pin: assert property (wr_hit && addr[5:0] == 6'h3E && wdata[0]
    |-> ##2 pin_sel) else $error("set lost");
  a_clear_pin: assert property (wr_hit && addr[5:0] == 6'h3F && wdata[0]
    |-> ##2 !pin_sel) else $error("clear lost");
  a_read_reg: assert property (rd_hit && addr[5:0] inside {6'h3D, 6'h3E, 6'h3F}
    |=> (rdata & 8'hF3) == {7'h00, pin_sel}) else $error("bad readback");
  a_read_gate: assert property (rd_hit && addr[5:0] == 6'h2F
    |=> rdata == 8'h00) else $error("gateway holds data");
  a_alt_pulse: assert property (alt_int |=> !alt_int) else $error("alt too long");
  a_reserved_zero: assert property (req && op == pwr_ctl_pkg::OP_WRITE
    |-> (wdata & 8'hF2) == 8'h00) else $error("reserved bit written");
endmodule // pwr_ctl_sva

// *** ulpi_power_control_ext_map_tb.sv ***
// bench: link and phy ends joined, driven through the software port
// assumes the link answers reads one cycle after the strobe
`timescale 1ns/100ps
module ulpi_power_control_ext_map_tb;
  logic clk = 0, sys_rst = 1, sw_wr = 0, sw_rd = 0, irq;
  logic bv = 0, tb_pin = 1, switch_req = 0, pin_o, pin_oe, pin_rst;
  logic [3:0] sw_addr = 4'h0;
  logic [7:0] sw_wdata = 8'h00, sw_rdata, v;
  int n_fail = 0, n_tests = 0, cnt;
  wire pin_lvl = pin_oe ? pin_o : tb_pin;
  // write addr, write data, read addr, expected
  logic [31:0] rows [7] = '{32'h2F0D3D00, 32'h3D0D3E0D, 32'h3F053F08, 32'h3E043D0C,
                           32'hBF0CBD00, 32'hBE013D01, 32'h3D002F00};
  pwr_link_if lnk ();
  pwr_phy pwr_phy_inst (.clk(clk), .sys_rst(sys_rst), .lnk(lnk), .bvalid_in(bv),
    .shared_pin_i(pin_lvl), .switch_req(switch_req), .shared_pin_o(pin_o),
    .shared_pin_oe(pin_oe), .pin_reset_r(pin_rst));
  pwr_link pwr_link_inst (.clk(clk), .sys_rst(sys_rst), .lnk(lnk), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .irq(irq));
  pwr_ctl_sva pwr_ctl_sva_inst (.clk(clk), .sys_rst(sys_rst), .req(lnk.req), .op(lnk.op),
    .ext(lnk.ext), .addr(lnk.addr), .wdata(lnk.wdata), .ack(lnk.ack), .rdata(lnk.rdata),
    .alt_int(lnk.alt_int), .pin_sel(lnk.pin_sel));
  task report_and_stop;
    $display("tests %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task chk(input string s, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (e !== g) begin
      n_fail++;
      $display("MISMATCH %s exp %h got %h", s, e, g);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge clk);
    sw_wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a);
    @(posedge clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clk);
    sw_rd <= 1'b0;
    @(negedge clk);
    v = sw_rdata;
  endtask
  task acc(input logic [7:0] a, input logic [1:0] o, input logic [7:0] d);
    wr(pwr_ctl_pkg::REG_CMD_ADDR, a);
    wr(pwr_ctl_pkg::REG_CMD_DATA, d);
    wr(pwr_ctl_pkg::REG_CMD_GO, {6'h00, o});
    repeat (4) @(posedge clk);
  endtask
  task settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  // alt pulses counted over a window longer than the sync lag
  task bvt(input logic b, input logic [7:0] e);
    @(posedge clk);
    bv <= b;
    cnt = 0;
    repeat (8) begin
      @(negedge clk);
      cnt = cnt + int'(lnk.alt_int === 1'b1);
    end
    chk("alt", e, 8'(cnt));
  endtask
  initial begin
    forever #25 clk = ~clk;
  end
  initial begin
    repeat (3000) @(posedge clk);
    n_fail++;
    report_and_stop;
  end
  initial begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    chk("pin_idle", 8'h01, {6'h00, pin_oe, pin_o});
    wr(pwr_ctl_pkg::REG_IRQ_MASK, 8'h07);
    foreach (rows[i]) begin
      acc(rows[i][31:24], pwr_ctl_pkg::OP_WRITE, rows[i][23:16]);
      acc(rows[i][15:8], pwr_ctl_pkg::OP_READ, 8'h00);
      rd(pwr_ctl_pkg::REG_RD_DATA);
      chk("rdata", rows[i][7:0], v);
      chk("irq", 8'h01, {7'h00, irq});
      wr(pwr_ctl_pkg::REG_IRQ_STATUS, 8'h07);
    end
    tb_pin <= 1'b0;
    switch_req <= 1'b1;
    settle(5);
    chk("pin_rst", 8'h01, {7'h00, pin_rst});
    acc(8'h3E, pwr_ctl_pkg::OP_WRITE, 8'h01);
    settle(4);
    chk("sw_mode", 8'h02, {6'h00, pin_oe, pin_o});
    chk("pin_rst", 8'h00, {7'h00, pin_rst});
    acc(8'h3D, pwr_ctl_pkg::OP_WRITE, 8'h09);
    wr(pwr_ctl_pkg::REG_IRQ_STATUS, 8'h07);
    wr(pwr_ctl_pkg::REG_IRQ_MASK, 8'h01);
    bvt(1'b1, 8'h00);
    bvt(1'b0, 8'h01);
    rd(pwr_ctl_pkg::REG_IRQ_STATUS);
    chk("status", 8'h02, v);
    chk("irq_mask", 8'h00, {7'h00, irq});
    wr(pwr_ctl_pkg::REG_IRQ_MASK, 8'h03);
    settle(2);
    chk("irq_on", 8'h01, {7'h00, irq});
    wr(pwr_ctl_pkg::REG_IRQ_STATUS, 8'h02);
    settle(2);
    chk("irq_off", 8'h00, {7'h00, irq});
    acc(8'h3D, pwr_ctl_pkg::OP_WRITE, 8'h05);
    bvt(1'b1, 8'h01);
    bvt(1'b0, 8'h00);
    wr(pwr_ctl_pkg::REG_IRQ_STATUS, 8'h07);
    acc(8'hC0, pwr_ctl_pkg::OP_READ, 8'h00);
    rd(pwr_ctl_pkg::REG_IRQ_STATUS);
    chk("bad_addr", 8'h04, v & 8'h04);
    rd(pwr_ctl_pkg::REG_CMD_ADDR);
    chk("cmd_addr", 8'hC0, v);
    rd(pwr_ctl_pkg::REG_LINK_STATE);
    chk("link_state", 8'h01, v);
    // mid-run reset must drop switch mode and clear status
    tb_pin <= 1'b1;
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    settle(2);
    chk("rst_pin", 8'h01, {6'h00, pin_oe, pin_o});
    chk("rst_pin_rst", 8'h00, {7'h00, pin_rst});
    rd(pwr_ctl_pkg::REG_LINK_STATE);
    chk("rst_state", 8'h00, v);
    rd(pwr_ctl_pkg::REG_IRQ_STATUS);
    chk("rst_status", 8'h00, v);
    report_and_stop;
  end
endmodule // ulpi_power_control_ext_map_tb
